// [dv/gmch_handler_props.sv]
// Checker for the command handler: slot firing, mode changes, prompt, errors.
// Assumes the hand-over latencies; bound to every handler instance.
`timescale 1ns/100ps
module gmch_handler_props
	import gmch_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic slot_tick,
	input wire logic ext_trig_mode,
	input wire logic ext_trigger,
	input wire logic dg_busy,
	input wire logic [ERR_W-1:0] err_events,
	input wire logic machine_exit,
	input wire logic error_query_done,
	input wire logic human_ready,
	input wire gmch_slot_type slot_out,
	input wire logic periodic_enable,
	input wire logic sampling_enable,
	input wire logic machine_ack,
	input wire logic [7:0] prompt_char,
	input wire logic prompt_valid,
	input wire logic [6:0] mode_code,
	input wire logic [ERR_W-1:0] ext_errors
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence s_ack;
		mode_code == MODE_MACHINE && machine_ack ##1 !machine_ack && !periodic_enable;
	endsequence
	sequence s_prompt;
		prompt_valid && prompt_char == CHAR_CR ##1 prompt_valid && prompt_char == CHAR_PROMPT;
	endsequence
	slot_fire_a: assert property (slot_tick && mode_code == MODE_NORMAL && !ext_trig_mode
		&& slot_out.kind != DG_TRIM |=> slot_out.start) else $error("slot tick lost");
	trig_fire_a: assert property (ext_trigger && mode_code == MODE_NORMAL && ext_trig_mode
		&& slot_out.kind != DG_TRIM |=> slot_out.start) else $error("trigger lost");
	mach_hold_a: assert property (mode_code == MODE_MACHINE_WAIT && dg_busy
		|=> mode_code != MODE_MACHINE) else $error("machine mode during datagram");
	mach_ack_a: assert property (mode_code == MODE_MACHINE_WAIT && !dg_busy |=> s_ack)
		else $error("machine entry not acknowledged");
	mach_quiet_a: assert property (mode_code == MODE_MACHINE && $past(mode_code) == MODE_MACHINE
		|-> !periodic_enable && sampling_enable) else $error("machine mode output wrong");
	mach_leave_a: assert property (mode_code == MODE_MACHINE && machine_exit
		|-> ##[1:3] mode_code == MODE_NORMAL && periodic_enable) else $error("no return");
	human_hold_a: assert property (mode_code == MODE_HUMAN_WAIT && dg_busy
		|=> mode_code != MODE_HUMAN) else $error("human mode during datagram");
	prompt_seq_a: assert property (mode_code == MODE_HUMAN && human_ready
		|-> ##[1:2] s_prompt) else $error("prompt sequence wrong");
	err_query_a: assert property (mode_code == MODE_HUMAN && error_query_done
		&& err_events == 16'h0_000 |=> ext_errors == 16'h0_000) else $error("errors kept");
endmodule : gmch_handler_props

bind gmch_handler gmch_handler_props gmch_handler_props_i (.clock, .sys_rst, .slot_tick,
	.ext_trig_mode, .ext_trigger, .dg_busy, .err_events, .machine_exit, .error_query_done,
	.human_ready, .slot_out, .periodic_enable, .sampling_enable, .machine_ack, .prompt_char,
	.prompt_valid, .mode_code, .ext_errors);

// [dv/gmch_host_model.sv]
// Host side model: sends command characters one per clock, then a carriage return.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/100ps
module gmch_host_model
	import gmch_pkg::*;
(
	input wire logic clock,
	output gmch_char_type rx_char
);
	initial rx_char = {1'b0, 8'hFF};
	task send_byte(input logic [7:0] b);
		rx_char = {1'b1, b};
		@(posedge clock);
		#1;
	endtask : send_byte
	task send_line(input logic [87:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) send_byte(w[i*8 +: 8]);
		send_byte(CHAR_CR);
		// Idle line shows the inverse, never the stale byte
		rx_char = {1'b0, ~CHAR_CR};
	endtask : send_line
endmodule : gmch_host_model

// [dv/tb_gmch_handler.sv]
// Testbench for the command handler: host model sends commands, bench drives the rest.
// Assumes a 100 MHz clock and the hand-over latencies of the handler.
`timescale 1ns/100ps
module tb_gmch_handler;
	import gmch_pkg::*;
	logic clock = 0, sys_rst = 1, slot_tick = 0, ext_trig_mode = 0, ext_trigger = 0, dg_busy = 0;
	logic dg_done = 0, subsample_tick = 0, human_exit = 0, machine_exit = 0, human_ready = 0;
	logic error_query_done = 0, listing_done = 0, tx_byte_valid = 0, tx_frame_start = 0;
	logic [7:0] check_flags = 8'h00, tx_byte = 8'h00, prompt_char, tx_crc;
	logic [ERR_W-1:0] err_events = 16'h0_000, ext_errors;
	logic periodic_enable, sampling_enable, machine_ack, listing_start, prompt_valid, unit_reset;
	logic [6:0] mode_code;
	gmch_char_type rx_char;
	gmch_slot_type slot_out;
	logic [7:0] letters [5] = '{CHAR_N, CHAR_I, CHAR_C, CHAR_T, CHAR_E};
	gmch_dg_type kinds [5] = '{DG_PART, DG_SERIAL, DG_CONFIG, DG_TRIM, DG_EXT_ERR};
	int miscompares = 0, n_checks = 0;
	always #5 clock = ~clock;
	gmch_host_model gmch_host_model_i (.clock, .rx_char);
	gmch_handler gmch_handler_i (.clock, .sys_rst, .rx_char, .slot_tick, .ext_trig_mode,
		.ext_trigger, .dg_busy, .dg_done, .subsample_tick, .check_flags, .err_events,
		.human_exit, .machine_exit, .error_query_done, .listing_done, .human_ready, .tx_byte,
		.tx_byte_valid, .tx_frame_start, .slot_out, .periodic_enable, .sampling_enable,
		.machine_ack, .listing_start, .prompt_char, .prompt_valid, .unit_reset, .mode_code,
		.ext_errors, .tx_crc);
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task cmd(input logic [7:0] c);
		gmch_host_model_i.send_line({80'h0, c}, 1);
		cyc(2);
	endtask : cmd
	// One slot pulse, or one external trigger pulse
	task fire(input logic trig);
		cyc(1);
		if (trig) ext_trigger = 1;
		else slot_tick = 1;
		cyc(1);
		ext_trigger = 0;
		slot_tick = 0;
	endtask : fire
	task t_startup;
		chk("mode", mode_code, MODE_STARTUP);
		err_events = 16'h0_001;
		cyc(1);
		err_events = 16'h0_000;
		cyc(70);
		chk("mode", mode_code, MODE_NORMAL);
		chk("errs", ext_errors, 16'h0_000);
	endtask : t_startup
	task t_letters;
		for (int i = 0; i < 5; i++) begin
			err_events = 16'h0_100;
			cmd(letters[i]);
			err_events = 16'h0_000;
			fire(0);
			chk("start", slot_out.start, 1);
			chk("kind", slot_out.kind, kinds[i]);
			if (kinds[i] == DG_TRIM) begin
				fire(0);
				chk("trim", slot_out.start, 0);
			end
			dg_done = 1;
			cyc(1);
			dg_done = 0;
			if (kinds[i] == DG_EXT_ERR) chk("errs", ext_errors, 0);
			fire(0);
			chk("discard", slot_out.discard_angle, 1);
			chk("meas", slot_out.kind, DG_MEAS);
		end
	endtask : t_letters
	task t_refused;
		cmd(8'h6E);
		cmd(8'h51);
		fire(0);
		chk("bad", slot_out.kind, DG_MEAS);
		cmd(CHAR_N);
		fire(0);
		chk("after", slot_out.kind, DG_PART);
		fire(0);
	endtask : t_refused
	task t_status;
		subsample_tick = 1;
		check_flags = 8'h01;
		cyc(1);
		check_flags = 8'h04;
		cyc(1);
		subsample_tick = 0;
		check_flags = 8'h00;
		fire(0);
		chk("status", slot_out.status, 8'h05);
		fire(0);
		chk("status", slot_out.status, 8'h00);
	endtask : t_status
	task t_trig;
		ext_trig_mode = 1;
		cmd(CHAR_C);
		fire(1);
		chk("trig", {slot_out.start, slot_out.kind}, {1'b1, DG_CONFIG});
		fire(1);
		ext_trig_mode = 0;
	endtask : t_trig
	task t_machine;
		dg_busy = 1;
		gmch_host_model_i.send_line(WORD_MACHINE, 11);
		cyc(3);
		chk("mode", mode_code, MODE_MACHINE_WAIT);
		dg_busy = 0;
		cyc(1);
		chk("ack", {machine_ack, mode_code}, {1'b1, MODE_MACHINE});
		fire(0);
		chk("idle", {slot_out.start, machine_ack, periodic_enable, sampling_enable}, 4'b0001);
		tx_frame_start = 1;
		cyc(1);
		tx_frame_start = 0;
		tx_byte = 8'h01;
		tx_byte_valid = 1;
		cyc(1);
		tx_byte_valid = 0;
		cyc(2);
		chk("crc", tx_crc, 8'h07);
		machine_exit = 1;
		cyc(1);
		machine_exit = 0;
		cyc(3);
		chk("exit", {mode_code, periodic_enable}, {MODE_NORMAL, 1'b1});
	endtask : t_machine
	task t_human;
		dg_busy = 1;
		gmch_host_model_i.send_line(WORD_HUMAN, 11);
		cyc(3);
		chk("mode", mode_code, MODE_HUMAN_WAIT);
		dg_busy = 0;
		cyc(1);
		chk("list", {listing_start, mode_code}, {1'b1, MODE_HUMAN});
		human_ready = 1;
		cyc(1);
		human_ready = 0;
		chk("cr", {prompt_valid, prompt_char}, {1'b1, CHAR_CR});
		cyc(1);
		chk("prompt", {prompt_valid, prompt_char}, {1'b1, CHAR_PROMPT});
		err_events = 16'h0_010;
		cyc(1);
		err_events = 16'h0_000;
		cyc(1);
		chk("acc", ext_errors, 16'h0_010);
		error_query_done = 1;
		cyc(1);
		error_query_done = 0;
		chk("errs", ext_errors, 16'h0_000);
		human_exit = 1;
		cyc(1);
		human_exit = 0;
		cyc(3);
	endtask : t_human
	task t_reset_cmd;
		gmch_host_model_i.send_line({80'h0, CHAR_R}, 1);
		cyc(1);
		chk("reset", {unit_reset, sampling_enable}, 2'b10);
		cyc(2);
		chk("mode", mode_code, MODE_STARTUP);
		cyc(70);
		chk("mode", mode_code, MODE_NORMAL);
	endtask : t_reset_cmd
	task give_verdict;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	initial begin
		cyc(4);
		sys_rst = 0;
		t_startup;
		t_letters;
		t_refused;
		t_status;
		t_trig;
		t_machine;
		t_human;
		t_reset_cmd;
		give_verdict;
	end
	// Whole run is about 280 cycles
	initial begin
		#50us;
		miscompares++;
		give_verdict;
	end
endmodule : tb_gmch_handler

// [rtl/gmch_crc8.sv]
// CRC-8 over a byte stream, one byte per cycle, for machine-link mode framing.
// Assumes the caller clears the running value at each frame start.
`timescale 1ns/100ps
module gmch_crc8
	import gmch_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic [7:0] crc
);
	logic [7:0] crc_reg;
	logic [7:0] crc_next;
	logic [7:0] stage [0:8];

	assign stage[0] = crc_reg ^ byte_data;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_bit
			assign stage[g + 1] = stage[g][7] ? ((stage[g] << 1) ^ CRC8_POLY) : (stage[g] << 1);
		end
	endgenerate
	assign crc_next = clear ? CRC8_INIT : (byte_valid ? stage[8] : crc_reg);
	assign crc = crc_reg;

	always_ff @(posedge clock) begin
		if (sys_rst)
			crc_reg <= CRC8_INIT;
		else
			crc_reg <= crc_next;
	end
endmodule : gmch_crc8

// [rtl/gmch_handler.sv]
// Command and mode handler of the rate sensor: parses normal-mode commands,
// schedules special datagrams into measurement slots, keeps status and errors.
// Assumes a UART elsewhere delivers received bytes and takes transmit bytes,
// and a datagram sequencer reports slot ticks and datagram completion.
// Operation
// - Machine-link mode commands and responses carry CRC-8 check value (here only transmitted bytes get a CRC-8).
// - Machine entry stops periodic datagrams and acknowledges machine mode.
// - Sampling and processing keep running while output is suspended.
// - Leaving machine mode returns to normal mode and periodic output.
// - Internal check errors set matching status flag bits.
// - Below 2000 samples/s status ORs all sub-sample flags.
// - Status flags not latched; accumulation restarts after each transmission.
// - Extended errors cleared when start-up phase completes.
// - Extended errors cleared right after extended error datagram sent.
// - Extended errors cleared after human mode accumulated error query answered.
// - Carriage return 0x0D terminates command and triggers decoding.
// - No echo, no error reports; act only on complete correct commands.
// - Incremental angle accumulated during special datagram is discarded.
// - Accept N, I, C, T, E, R letters and two mode-entry words.
// - Special datagram takes the next measurement slot instead of it.
// - With external trigger, special datagram goes on next trigger.
// - Trim datagram may displace several slots when longer.
// - Reset letter forces full unit reset through start-up.
// - Human mode entry waits for current datagram to finish.
// - Human mode entry first outputs configuration listing.
// - Machine mode entry waits for current datagram to finish.
// - Human mode ready prompt is carriage return then '>'.
`timescale 1ns/100ps
module gmch_handler
	import gmch_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire gmch_char_type rx_char,
	input wire logic slot_tick,
	input wire logic ext_trig_mode,
	input wire logic ext_trigger,
	input wire logic dg_busy,
	input wire logic dg_done,
	input wire logic subsample_tick,
	input wire logic [7:0] check_flags,
	input wire logic [ERR_W-1:0] err_events,
	input wire logic human_exit,
	input wire logic machine_exit,
	input wire logic error_query_done,
	input wire logic listing_done,
	input wire logic human_ready,
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_valid,
	input wire logic tx_frame_start,
	output gmch_slot_type slot_out,
	output logic periodic_enable,
	output logic sampling_enable,
	output logic machine_ack,
	output logic listing_start,
	output logic [7:0] prompt_char,
	output logic prompt_valid,
	output logic unit_reset,
	output logic [6:0] mode_code,
	output logic [ERR_W-1:0] ext_errors,
	output logic [7:0] tx_crc
);
	gmch_mode_type mode_reg, mode_next;
	logic [7:0] buf_reg [0:CMD_LEN-1];
	logic [3:0] len_reg;
	logic overflow_reg;
	logic [15:0] start_cnt_reg;
	gmch_dg_type pend_reg;
	logic pend_valid_reg;
	logic discard_reg;
	logic [7:0] status_acc_reg;
	logic [ERR_W-1:0] err_reg;
	gmch_slot_type slot_reg;
	logic machine_ack_reg;
	logic listing_reg;
	logic prompt_valid_reg;
	logic prompt_phase_reg;
	logic reset_reg;
	logic [7:0] prompt_reg;
	logic trim_busy_reg;

	wire logic is_cr = rx_char.valid && (rx_char.data == CHAR_CR);
	wire logic is_upper = (rx_char.data >= CHAR_UP_A) && (rx_char.data <= CHAR_UP_Z);
	wire logic in_normal = (mode_reg == MODE_NORMAL);
	wire logic exec = in_normal && is_cr && !overflow_reg;
	wire logic one_letter = (len_reg == 4'h1);
	wire logic [7:0] letter = buf_reg[0];
	logic [87:0] word_vec;
	genvar gi;
	generate
		for (gi = 0; gi < 11; gi++) begin : g_word
			assign word_vec[87-8*gi -: 8] = buf_reg[gi];
		end
	endgenerate
	wire logic eleven = (len_reg == 4'hB);
	wire logic cmd_part = exec && one_letter && (letter == CHAR_N);
	wire logic cmd_serial = exec && one_letter && (letter == CHAR_I);
	wire logic cmd_config = exec && one_letter && (letter == CHAR_C);
	wire logic cmd_trim = exec && one_letter && (letter == CHAR_T);
	wire logic cmd_err = exec && one_letter && (letter == CHAR_E);
	wire logic cmd_reset = exec && one_letter && (letter == CHAR_R);
	wire logic cmd_human = exec && eleven && (word_vec == WORD_HUMAN);
	wire logic cmd_machine = exec && eleven && (word_vec == WORD_MACHINE);
	wire logic cmd_special = cmd_part || cmd_serial || cmd_config || cmd_trim || cmd_err;
	wire gmch_dg_type cmd_kind = cmd_part ? DG_PART : cmd_serial ? DG_SERIAL :
		cmd_config ? DG_CONFIG : cmd_trim ? DG_TRIM : DG_EXT_ERR;

	// Trigger replaces slot in external mode
	wire logic slot_now = ext_trig_mode ? ext_trigger : slot_tick;
	// Periodic output in normal mode and both mode-entry wait states
	wire logic periodic_on = in_normal || (mode_reg == MODE_HUMAN_WAIT) ||
		(mode_reg == MODE_MACHINE_WAIT);
	// Long trim datagram holds off slots
	wire logic fire = periodic_on && slot_now && !trim_busy_reg;
	wire logic fire_special = fire && pend_valid_reg;
	wire logic startup_done = (mode_reg == MODE_STARTUP) && (start_cnt_reg == STARTUP_CYCLES);
	wire logic err_sent = dg_done && (slot_reg.kind == DG_EXT_ERR);
	wire logic err_clear = startup_done || err_sent || error_query_done;
	wire logic [7:0] status_now = status_acc_reg | (subsample_tick ? check_flags : 8'h00);
	wire logic [7:0] status_acc_next = fire ? 8'h00 : status_now;
	// Set beats clear so an error in the clearing cycle is kept
	wire logic [ERR_W-1:0] err_next = (err_clear ? {ERR_W{1'b0}} : err_reg) | err_events;

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			MODE_STARTUP: if (startup_done) mode_next = MODE_NORMAL;
			MODE_NORMAL: begin
				if (cmd_reset)
					mode_next = MODE_RESET;
				else if (cmd_human)
					mode_next = MODE_HUMAN_WAIT;
				else if (cmd_machine)
					mode_next = MODE_MACHINE_WAIT;
			end
			MODE_HUMAN_WAIT: if (!dg_busy) mode_next = MODE_HUMAN;
			MODE_MACHINE_WAIT: if (!dg_busy) mode_next = MODE_MACHINE;
			MODE_HUMAN: if (human_exit) mode_next = MODE_NORMAL;
			MODE_MACHINE: if (machine_exit) mode_next = MODE_NORMAL;
			MODE_RESET: mode_next = MODE_STARTUP;
			default: mode_next = MODE_STARTUP;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			mode_reg <= MODE_STARTUP;
		else
			mode_reg <= mode_next;
	end

	always_ff @(posedge clock) begin
		if (sys_rst || (mode_reg == MODE_RESET))
			start_cnt_reg <= 16'h0_000;
		else if (mode_reg == MODE_STARTUP)
			start_cnt_reg <= start_cnt_reg + 16'h0_001;
	end

	// Collect upper case; any other character silently spoils the command
	always_ff @(posedge clock) begin
		if (sys_rst || !in_normal || is_cr) begin
			len_reg <= 4'h0;
			overflow_reg <= 1'b0;
		end else if (rx_char.valid) begin
			if (!is_upper || (len_reg == CMD_LEN_MAX))
				overflow_reg <= 1'b1;
			else
				len_reg <= len_reg + 4'h1;
		end
	end

	generate
		for (gi = 0; gi < CMD_LEN; gi++) begin : g_buf
			always_ff @(posedge clock) begin
				if (sys_rst)
					buf_reg[gi] <= 8'h00;
				else if (in_normal && rx_char.valid && !is_cr && is_upper &&
						(len_reg == 4'(gi)))
					buf_reg[gi] <= rx_char.data;
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (sys_rst || (mode_reg == MODE_STARTUP)) begin
			pend_valid_reg <= 1'b0;
			pend_reg <= DG_MEAS;
		end else if (cmd_special) begin
			pend_valid_reg <= 1'b1;
			pend_reg <= cmd_kind;
		end else if (fire_special) begin
			pend_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			slot_reg <= '{start: 1'b0, kind: DG_MEAS, status: STATUS_RESET, discard_angle: 1'b0};
			discard_reg <= 1'b0;
			trim_busy_reg <= 1'b0;
			status_acc_reg <= STATUS_RESET;
		end else begin
			status_acc_reg <= status_acc_next;
			slot_reg.start <= fire;
			if (fire) begin
				slot_reg.kind <= fire_special ? pend_reg : DG_MEAS;
				slot_reg.status <= status_now;
				slot_reg.discard_angle <= !fire_special && discard_reg;
				discard_reg <= fire_special;
			end
			if (fire_special && (pend_reg == DG_TRIM))
				trim_busy_reg <= 1'b1;
			else if (dg_done)
				trim_busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			err_reg <= EXT_ERR_RESET;
		else
			err_reg <= err_next;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			machine_ack_reg <= 1'b0;
			listing_reg <= 1'b0;
			prompt_valid_reg <= 1'b0;
			prompt_phase_reg <= 1'b0;
			prompt_reg <= 8'h00;
			reset_reg <= 1'b0;
		end else begin
			machine_ack_reg <= (mode_reg == MODE_MACHINE_WAIT) && (mode_next == MODE_MACHINE);
			listing_reg <= (mode_reg == MODE_HUMAN_WAIT) && (mode_next == MODE_HUMAN);
			reset_reg <= (mode_reg == MODE_RESET);
			prompt_valid_reg <= 1'b0;
			if (mode_reg == MODE_HUMAN && human_ready && !prompt_phase_reg) begin
				prompt_reg <= CHAR_CR;
				prompt_valid_reg <= 1'b1;
				prompt_phase_reg <= 1'b1;
			end else if (prompt_phase_reg) begin
				prompt_reg <= CHAR_PROMPT;
				prompt_valid_reg <= 1'b1;
				prompt_phase_reg <= 1'b0;
			end
		end
	end

	gmch_crc8 u_crc (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(tx_frame_start),
		.byte_valid(tx_byte_valid && (mode_reg == MODE_MACHINE)),
		.byte_data(tx_byte),
		.crc(tx_crc)
	);

	logic periodic_reg;
	always_ff @(posedge clock) begin
		if (sys_rst)
			periodic_reg <= 1'b0;
		else
			periodic_reg <= periodic_on;
	end

	// Sampling flag registered
	// Drops only for the reset pulse, so filters never restart on mode changes
	logic sampling_reg;
	always_ff @(posedge clock) begin
		if (sys_rst)
			sampling_reg <= 1'b1;
		else
			sampling_reg <= (mode_reg != MODE_RESET);
	end

	assign slot_out = slot_reg;
	assign periodic_enable = periodic_reg;
	assign sampling_enable = sampling_reg;
	assign machine_ack = machine_ack_reg;
	assign listing_start = listing_reg;
	assign prompt_char = prompt_reg;
	assign prompt_valid = prompt_valid_reg;
	assign unit_reset = reset_reg;
	assign mode_code = mode_reg;
	assign ext_errors = err_reg;
endmodule : gmch_handler

// [shared/gmch_pkg.sv]
// Package for the gyro mode and command handler: characters, modes, types.
// Assumes byte-wide receive characters and a one-byte sensor status flag vector.
package gmch_pkg;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [7:0] CHAR_PROMPT = 8'h3E;
	localparam logic [7:0] CHAR_UP_A = 8'h41;
	localparam logic [7:0] CHAR_UP_Z = 8'h5A;
	localparam logic [7:0] CHAR_N = 8'h4E;
	localparam logic [7:0] CHAR_I = 8'h49;
	localparam logic [7:0] CHAR_C = 8'h43;
	localparam logic [7:0] CHAR_T = 8'h54;
	localparam logic [7:0] CHAR_E = 8'h45;
	localparam logic [7:0] CHAR_R = 8'h52;
	localparam logic [7:0] CHAR_X = 8'h78;
	localparam logic [7:0] CRC8_POLY = 8'h07;
	localparam logic [7:0] CRC8_INIT = 8'h00;
	localparam int CMD_LEN = 12;
	localparam logic [3:0] CMD_LEN_MAX = 4'h0_C;
	localparam int INT_RATE_SPS = 2000;
	localparam int CLK_HZ = 100000000;
	localparam int SUBSAMPLE_CYCLES = CLK_HZ / INT_RATE_SPS;
	localparam logic [15:0] STARTUP_CYCLES = 16'h0_040;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] EXT_ERR_RESET = 16'h0_000;
	localparam int ERR_W = 16;
	// Word commands stored as 11-character strings, first character in the high byte
	localparam logic [87:0] WORD_HUMAN = 88'h53_4552_5649_4345_4D4F_4445;
	localparam logic [87:0] WORD_MACHINE = 88'h55_5449_4C49_5459_4D4F_4445;

	typedef enum logic [6:0] {
		MODE_STARTUP = 7'b000_0001,
		MODE_NORMAL = 7'b000_0010,
		MODE_HUMAN_WAIT = 7'b000_0100,
		MODE_HUMAN = 7'b000_1000,
		MODE_MACHINE_WAIT = 7'b001_0000,
		MODE_MACHINE = 7'b010_0000,
		MODE_RESET = 7'b100_0000
	} gmch_mode_type;

	typedef enum logic [5:0] {
		DG_MEAS = 6'b00_0001,
		DG_PART = 6'b00_0010,
		DG_SERIAL = 6'b00_0100,
		DG_CONFIG = 6'b00_1000,
		DG_TRIM = 6'b01_0000,
		DG_EXT_ERR = 6'b10_0000
	} gmch_dg_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} gmch_char_type;

	typedef struct packed {
		logic start;
		gmch_dg_type kind;
		logic [7:0] status;
		logic discard_angle;
	} gmch_slot_type;
endpackage : gmch_pkg
